/* File: rtl/loop_cfg_fields.sv */
// configuration field decoder for the dual-loop clock conditioner
// Notes on behaviour
// - pump current code 010..111 gives 20,80,25,50,100,400 uA; 000/001 reserved
// - slope select 0 means negative-slope oscillator, 1 positive-slope
// - crystal amplifier on at 1, off at 0; host sets it for crystals
// - auxiliary output enable resets to 0, port disabled by default
// - global clock enable bit 18 resets to 1; 1 enables output clocks
// - sleep bit at 1 powers everything down, overriding the enable, doubler and float bits and the pin
// - doubler at 1 routes oscillator input around divider through doubler
// - doubler bit resets to 0; host uses it only below 50 MHz
// - first resistor code: <600, 10k, 20k, 30k, 40k; 101-111 invalid
// - second resistor code: <200, 10k, 20k, 30k, 40k; 101-111 invalid
// - capacitor code gives twelve fixed pairs; 1100-1111 reserved
// - first pump floats when its float bit is 1, drives at 0
// - second pump floats when its float bit is 1, drives at 0
`timescale 1ns/1ps
module loop_cfg_fields (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_WR_EN,
    input  wire logic [2:0]  I_FIRST_LOOP_PUMP_CURRENT_CODE,
    input  wire logic        I_FIRST_LOOP_PUMP_SLOPE_SELECT,
    input  wire logic        I_CRYSTAL_AMPLIFIER_ENABLE,
    input  wire logic        I_AUX_OUTPUT_ENABLE,
    input  wire logic        I_GLOBAL_CLOCK_ENABLE,
    input  wire logic        I_WHOLE_DEVICE_SLEEP_BIT,
    input  wire logic        I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE,
    input  wire logic [2:0]  I_FILTER_FIRST_RESISTOR_CODE,
    input  wire logic [2:0]  I_FILTER_SECOND_RESISTOR_CODE,
    input  wire logic [3:0]  I_FILTER_CAPACITOR_PAIR_CODE,
    input  wire logic        I_FIRST_LOOP_PUMP_FLOAT_BIT,
    input  wire logic        I_SECOND_LOOP_PUMP_FLOAT_BIT,
    input  wire logic        I_OUTPUT_ENABLE_PIN,
    output logic [8:0]       O_FIRST_LOOP_PUMP_CURRENT_UA,
    output logic             O_FIRST_LOOP_PUMP_CODE_BAD,
    output logic             O_FIRST_LOOP_PUMP_INVERT,
    output logic             O_CRYSTAL_AMPLIFIER_ON,
    output logic             O_AUX_OUTPUT_ON,
    output logic             O_OUTPUT_CLOCKS_ON,
    output logic             O_DEVICE_POWERED,
    output logic             O_DOUBLER_PATH_SELECT,
    output logic             O_REFERENCE_DIVIDER_USED,
    output logic [15:0]      O_FILTER_FIRST_RESISTOR_OHM,
    output logic [15:0]      O_FILTER_SECOND_RESISTOR_OHM,
    output logic             O_FILTER_RESISTOR_CODE_BAD,
    output logic [7:0]       O_FILTER_FIRST_CAP_PF,
    output logic [7:0]       O_FILTER_SECOND_CAP_PF,
    output logic             O_FILTER_CAP_CODE_BAD,
    output logic             O_FIRST_LOOP_PUMP_OUTPUT_OE,
    output logic             O_SECOND_LOOP_PUMP_OUTPUT_OE
);

    ////////////////////////////////////////////////////////////////////////////
    // stored fields

    logic [2:0] pump_code_reg;
    logic       slope_reg;
    logic       xtal_en_reg;
    logic       aux_en_reg;
    logic       global_en_reg;
    logic       sleep_reg;
    logic       doubler_reg;
    logic [2:0] res1_code_reg;
    logic [2:0] res2_code_reg;
    logic [3:0] cap_code_reg;
    logic       float1_reg;
    logic       float2_reg;
    logic       pin_s1_reg;
    logic       pin_s2_reg;
    logic       pin_s3_reg;
    logic       pin_reg;

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pump_code_reg <= loop_cfg_pkg::RST_PUMP_CODE;
            slope_reg     <= loop_cfg_pkg::RST_SLOPE;
            xtal_en_reg   <= loop_cfg_pkg::RST_XTAL_EN;
            aux_en_reg    <= loop_cfg_pkg::RST_AUX_EN;
            global_en_reg <= loop_cfg_pkg::RST_GLOBAL_EN;
            sleep_reg     <= loop_cfg_pkg::RST_SLEEP;
            doubler_reg   <= loop_cfg_pkg::RST_DOUBLER_EN;
            res1_code_reg <= loop_cfg_pkg::RST_RES_CODE;
            res2_code_reg <= loop_cfg_pkg::RST_RES_CODE;
            cap_code_reg  <= loop_cfg_pkg::RST_CAP_CODE;
            float1_reg    <= loop_cfg_pkg::RST_FLOAT;
            float2_reg    <= loop_cfg_pkg::RST_FLOAT;
        end else if (I_WR_EN) begin
            pump_code_reg <= I_FIRST_LOOP_PUMP_CURRENT_CODE;
            slope_reg     <= I_FIRST_LOOP_PUMP_SLOPE_SELECT;
            xtal_en_reg   <= I_CRYSTAL_AMPLIFIER_ENABLE;
            aux_en_reg    <= I_AUX_OUTPUT_ENABLE;
            global_en_reg <= I_GLOBAL_CLOCK_ENABLE;
            sleep_reg     <= I_WHOLE_DEVICE_SLEEP_BIT;
            doubler_reg   <= I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE;
            res1_code_reg <= I_FILTER_FIRST_RESISTOR_CODE;
            res2_code_reg <= I_FILTER_SECOND_RESISTOR_CODE;
            cap_code_reg  <= I_FILTER_CAPACITOR_PAIR_CODE;
            float1_reg    <= I_FIRST_LOOP_PUMP_FLOAT_BIT;
            float2_reg    <= I_SECOND_LOOP_PUMP_FLOAT_BIT;
        end
    end

    // output enable pin is asynchronous; change counts once stages two and three agree
    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pin_s1_reg <= 1'h0;
            pin_s2_reg <= 1'h0;
            pin_s3_reg <= 1'h0;
            pin_reg    <= 1'h0;
        end else begin
            pin_s1_reg <= I_OUTPUT_ENABLE_PIN;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                pin_reg <= pin_s3_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decode

    logic [8:0]  cur_next;
    logic        cur_bad_next;
    logic [15:0] r1_next;
    logic [15:0] r2_next;
    logic        r_bad_next;
    logic [7:0]  c1_next;
    logic [7:0]  c2_next;
    logic        c_bad_next;

    always_comb begin
        cur_bad_next = 1'h0;
        case (pump_code_reg)
            3'h2:    cur_next = loop_cfg_pkg::CUR_20;
            3'h3:    cur_next = loop_cfg_pkg::CUR_80;
            3'h4:    cur_next = loop_cfg_pkg::CUR_25;
            3'h5:    cur_next = loop_cfg_pkg::CUR_50;
            3'h6:    cur_next = loop_cfg_pkg::CUR_100;
            3'h7:    cur_next = loop_cfg_pkg::CUR_400;
            default: begin
                // reserved: no current rather than a guess
                cur_next     = 9'h000;
                cur_bad_next = 1'h1;
            end
        endcase
    end

    function automatic logic [15:0] res_decode(input logic [2:0] code,
                                               input logic [15:0] floor_ohm);
        case (code)
            3'h0:    res_decode = floor_ohm;
            3'h1:    res_decode = loop_cfg_pkg::R_10K;
            3'h2:    res_decode = loop_cfg_pkg::R_20K;
            3'h3:    res_decode = loop_cfg_pkg::R_30K;
            3'h4:    res_decode = loop_cfg_pkg::R_40K;
            default: res_decode = 16'h0000;
        endcase
    endfunction

    always_comb begin
        r1_next    = res_decode(res1_code_reg, loop_cfg_pkg::R1_FLOOR);
        r2_next    = res_decode(res2_code_reg, loop_cfg_pkg::R2_FLOOR);
        r_bad_next = (res1_code_reg > 3'h4) || (res2_code_reg > 3'h4);
    end

    always_comb begin
        c_bad_next = 1'h0;
        case (cap_code_reg)
            4'h0:    {c1_next, c2_next} = {loop_cfg_pkg::C_0, loop_cfg_pkg::C_10};
            4'h1:    {c1_next, c2_next} = {loop_cfg_pkg::C_0, loop_cfg_pkg::C_60};
            4'h2:    {c1_next, c2_next} = {loop_cfg_pkg::C_50, loop_cfg_pkg::C_10};
            4'h3:    {c1_next, c2_next} = {loop_cfg_pkg::C_0, loop_cfg_pkg::C_110};
            4'h4:    {c1_next, c2_next} = {loop_cfg_pkg::C_50, loop_cfg_pkg::C_110};
            4'h5:    {c1_next, c2_next} = {loop_cfg_pkg::C_100, loop_cfg_pkg::C_110};
            4'h6:    {c1_next, c2_next} = {loop_cfg_pkg::C_0, loop_cfg_pkg::C_160};
            4'h7:    {c1_next, c2_next} = {loop_cfg_pkg::C_50, loop_cfg_pkg::C_160};
            4'h8:    {c1_next, c2_next} = {loop_cfg_pkg::C_100, loop_cfg_pkg::C_10};
            4'h9:    {c1_next, c2_next} = {loop_cfg_pkg::C_100, loop_cfg_pkg::C_60};
            4'ha:    {c1_next, c2_next} = {loop_cfg_pkg::C_150, loop_cfg_pkg::C_110};
            4'hb:    {c1_next, c2_next} = {loop_cfg_pkg::C_150, loop_cfg_pkg::C_60};
            default: begin
                c1_next    = loop_cfg_pkg::C_0;
                c2_next    = loop_cfg_pkg::C_0;
                c_bad_next = 1'h1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs; sleep overrides every enable, doubler and float bit and the pin

    always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_FIRST_LOOP_PUMP_CURRENT_UA <= 9'h000;
            O_FIRST_LOOP_PUMP_CODE_BAD   <= 1'h0;
            O_FIRST_LOOP_PUMP_INVERT     <= 1'h0;
            O_CRYSTAL_AMPLIFIER_ON       <= 1'h0;
            O_AUX_OUTPUT_ON              <= 1'h0;
            O_OUTPUT_CLOCKS_ON           <= 1'h0;
            O_DEVICE_POWERED             <= 1'h0;
            O_DOUBLER_PATH_SELECT        <= 1'h0;
            O_REFERENCE_DIVIDER_USED     <= 1'h0;
            O_FILTER_FIRST_RESISTOR_OHM  <= 16'h0000;
            O_FILTER_SECOND_RESISTOR_OHM <= 16'h0000;
            O_FILTER_RESISTOR_CODE_BAD   <= 1'h0;
            O_FILTER_FIRST_CAP_PF        <= 8'h00;
            O_FILTER_SECOND_CAP_PF       <= 8'h00;
            O_FILTER_CAP_CODE_BAD        <= 1'h0;
            O_FIRST_LOOP_PUMP_OUTPUT_OE  <= 1'h0;
            O_SECOND_LOOP_PUMP_OUTPUT_OE <= 1'h0;
        end else begin
            O_FIRST_LOOP_PUMP_CURRENT_UA <= cur_next;
            O_FIRST_LOOP_PUMP_CODE_BAD   <= cur_bad_next;
            O_FIRST_LOOP_PUMP_INVERT     <= (slope_reg == loop_cfg_pkg::SLOPE_NEGATIVE);
            O_CRYSTAL_AMPLIFIER_ON       <= xtal_en_reg && !sleep_reg;
            O_AUX_OUTPUT_ON              <= aux_en_reg && !sleep_reg;
            O_OUTPUT_CLOCKS_ON           <= global_en_reg && pin_reg
                                            && !sleep_reg;
            O_DEVICE_POWERED             <= !sleep_reg;
            O_DOUBLER_PATH_SELECT        <= doubler_reg && !sleep_reg;
            O_REFERENCE_DIVIDER_USED     <= !doubler_reg && !sleep_reg;
            O_FILTER_FIRST_RESISTOR_OHM  <= r1_next;
            O_FILTER_SECOND_RESISTOR_OHM <= r2_next;
            O_FILTER_RESISTOR_CODE_BAD   <= r_bad_next;
            O_FILTER_FIRST_CAP_PF        <= c1_next;
            O_FILTER_SECOND_CAP_PF       <= c2_next;
            O_FILTER_CAP_CODE_BAD        <= c_bad_next;
            // a powered-down pump cannot drive either
            O_FIRST_LOOP_PUMP_OUTPUT_OE  <= !float1_reg && !sleep_reg;
            O_SECOND_LOOP_PUMP_OUTPUT_OE <= !float2_reg && !sleep_reg;
        end
    end

endmodule // loop_cfg_fields

/* File: rtl/loop_cfg_pkg.sv */
// constants for the loop configuration field decoder
package loop_cfg_pkg;
    // field widths
    localparam int PUMP_CODE_W = 3;
    localparam int RES_CODE_W  = 3;
    localparam int CAP_CODE_W  = 4;
    localparam int CUR_W       = 9;   // microamps
    localparam int CAP_W       = 8;   // picofarads
    localparam int RES_W       = 16;  // ohms

    // global clock enable position in the thirteenth register
    localparam int GLOBAL_EN_BIT = 18;

    // reset values
    localparam logic RST_AUX_EN     = 1'h0;
    localparam logic RST_GLOBAL_EN  = 1'h1;
    localparam logic RST_DOUBLER_EN = 1'h0;
    localparam logic RST_SLEEP      = 1'h0;
    localparam logic RST_XTAL_EN    = 1'h0;
    localparam logic RST_SLOPE      = 1'h0;
    localparam logic RST_FLOAT      = 1'h0;
    localparam logic [PUMP_CODE_W-1:0] RST_PUMP_CODE = 3'h2;
    localparam logic [RES_CODE_W-1:0]  RST_RES_CODE  = 3'h0;
    localparam logic [CAP_CODE_W-1:0]  RST_CAP_CODE  = 4'h0;

    // slope select encoding
    localparam logic SLOPE_NEGATIVE = 1'h0;
    localparam logic SLOPE_POSITIVE = 1'h1;

    // pump currents, microamps
    localparam logic [CUR_W-1:0] CUR_20  = 9'h014;
    localparam logic [CUR_W-1:0] CUR_80  = 9'h050;
    localparam logic [CUR_W-1:0] CUR_25  = 9'h019;
    localparam logic [CUR_W-1:0] CUR_50  = 9'h032;
    localparam logic [CUR_W-1:0] CUR_100 = 9'h064;
    localparam logic [CUR_W-1:0] CUR_400 = 9'h190;

    // resistor values, ohms; code 000 is the low-ohm floor
    localparam logic [RES_W-1:0] R1_FLOOR = 16'h0258;  // 600
    localparam logic [RES_W-1:0] R2_FLOOR = 16'h00c8;  // 200
    localparam logic [RES_W-1:0] R_10K    = 16'h2710;
    localparam logic [RES_W-1:0] R_20K    = 16'h4e20;
    localparam logic [RES_W-1:0] R_30K    = 16'h7530;
    localparam logic [RES_W-1:0] R_40K    = 16'h9c40;

    // capacitor values, picofarads
    localparam logic [CAP_W-1:0] C_0   = 8'h00;
    localparam logic [CAP_W-1:0] C_10  = 8'h0a;
    localparam logic [CAP_W-1:0] C_50  = 8'h32;
    localparam logic [CAP_W-1:0] C_60  = 8'h3c;
    localparam logic [CAP_W-1:0] C_100 = 8'h64;
    localparam logic [CAP_W-1:0] C_110 = 8'h6e;
    localparam logic [CAP_W-1:0] C_150 = 8'h96;
    localparam logic [CAP_W-1:0] C_160 = 8'ha0;
endpackage

/* File: verif/loop_cfg_checker.sv */
// concurrent checks on the loop configuration field decoder ports
`timescale 1ns/1ps
module loop_cfg_checker (
    input wire logic       I_CORE_CLK,
    input wire logic       I_RSTN,
    input wire logic       I_WR_EN,
    input wire logic [2:0] I_FIRST_LOOP_PUMP_CURRENT_CODE,
    input wire logic       I_FIRST_LOOP_PUMP_SLOPE_SELECT,
    input wire logic       I_WHOLE_DEVICE_SLEEP_BIT,
    input wire logic       I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE,
    input wire logic [3:0] I_FILTER_CAPACITOR_PAIR_CODE,
    input wire logic       I_FIRST_LOOP_PUMP_FLOAT_BIT,
    input wire logic       I_SECOND_LOOP_PUMP_FLOAT_BIT,
    input wire logic       I_OUTPUT_ENABLE_PIN,
    input wire logic [8:0] O_FIRST_LOOP_PUMP_CURRENT_UA,
    input wire logic       O_FIRST_LOOP_PUMP_INVERT,
    input wire logic       O_OUTPUT_CLOCKS_ON,
    input wire logic       O_DEVICE_POWERED,
    input wire logic       O_DOUBLER_PATH_SELECT,
    input wire logic       O_REFERENCE_DIVIDER_USED,
    input wire logic       O_FILTER_CAP_CODE_BAD,
    input wire logic       O_FIRST_LOOP_PUMP_OUTPUT_OE,
    input wire logic       O_SECOND_LOOP_PUMP_OUTPUT_OE
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RSTN);
    // a write lands in the outputs two samples after the strobe is seen
    sequence wr_awake_s; I_WR_EN && !I_WHOLE_DEVICE_SLEEP_BIT; endsequence
    sequence all_off_s;
        !O_DEVICE_POWERED && !O_OUTPUT_CLOCKS_ON && !O_DOUBLER_PATH_SELECT
            && !O_FIRST_LOOP_PUMP_OUTPUT_OE && !O_SECOND_LOOP_PUMP_OUTPUT_OE;
    endsequence
    // six samples cover the three-stage pin synchroniser
    sequence pin_low_s; !I_OUTPUT_ENABLE_PIN [*6]; endsequence
    sleep_override_a: assert property (I_WR_EN && I_WHOLE_DEVICE_SLEEP_BIT
        |-> ##2 all_off_s)
        else $error("sleep write left a block running");
    reset_defaults_a: assert property ($rose(I_RSTN) |-> ##1 (O_DEVICE_POWERED
        && O_REFERENCE_DIVIDER_USED && O_FIRST_LOOP_PUMP_CURRENT_UA == loop_cfg_pkg::CUR_20))
        else $error("defaults wrong after reset");
    doubler_route_a: assert property (wr_awake_s |-> ##2
        (O_DOUBLER_PATH_SELECT == $past(I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE, 2)
        && O_REFERENCE_DIVIDER_USED == !O_DOUBLER_PATH_SELECT))
        else $error("doubler path wrong");
    top_current_a: assert property (I_WR_EN && I_FIRST_LOOP_PUMP_CURRENT_CODE == 3'h7
        |-> ##2 O_FIRST_LOOP_PUMP_CURRENT_UA == loop_cfg_pkg::CUR_400)
        else $error("pump current wrong for top code");
    slope_invert_a: assert property (I_WR_EN |-> ##2
        O_FIRST_LOOP_PUMP_INVERT != $past(I_FIRST_LOOP_PUMP_SLOPE_SELECT, 2))
        else $error("slope polarity wrong");
    pump_float_a: assert property (wr_awake_s |-> ##2
        (O_FIRST_LOOP_PUMP_OUTPUT_OE != $past(I_FIRST_LOOP_PUMP_FLOAT_BIT, 2)
        && O_SECOND_LOOP_PUMP_OUTPUT_OE != $past(I_SECOND_LOOP_PUMP_FLOAT_BIT, 2)))
        else $error("pump drive enable wrong");
    cap_reserved_a: assert property (I_WR_EN |-> ##2
        O_FILTER_CAP_CODE_BAD == ($past(I_FILTER_CAPACITOR_PAIR_CODE, 2) >= 4'hc))
        else $error("capacitor code flag wrong");
    pin_gates_a: assert property (pin_low_s |-> !O_OUTPUT_CLOCKS_ON)
        else $error("clocks on with pin low");
endmodule // loop_cfg_checker

/* File: verif/tb.sv */
// self-checking bench for the loop configuration field decoder
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        rst_n;
    logic        wr_en;
    logic        pin;
    logic [20:0] f;
    wire  [68:0] outs;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [15:0] cap_tab [12] = '{16'h000a, 16'h003c, 16'h320a, 16'h006e, 16'h326e, 16'h646e,
                                  16'h00a0, 16'h32a0, 16'h640a, 16'h643c, 16'h966e, 16'h963c};
    logic [8:0]  cur_tab [8] = '{9'h000, 9'h000, loop_cfg_pkg::CUR_20, loop_cfg_pkg::CUR_80,
        loop_cfg_pkg::CUR_25, loop_cfg_pkg::CUR_50, loop_cfg_pkg::CUR_100, loop_cfg_pkg::CUR_400};
    ////////////////////////////////////////////////////////////////////////
    loop_cfg_fields loop_cfg_fields_inst (
        .I_CORE_CLK(clk), .I_RSTN(rst_n), .I_WR_EN(wr_en),
        .I_FIRST_LOOP_PUMP_CURRENT_CODE(f[20:18]), .I_FIRST_LOOP_PUMP_SLOPE_SELECT(f[17]),
        .I_CRYSTAL_AMPLIFIER_ENABLE(f[16]), .I_AUX_OUTPUT_ENABLE(f[15]),
        .I_GLOBAL_CLOCK_ENABLE(f[14]), .I_WHOLE_DEVICE_SLEEP_BIT(f[13]),
        .I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE(f[12]), .I_FILTER_FIRST_RESISTOR_CODE(f[11:9]),
        .I_FILTER_SECOND_RESISTOR_CODE(f[8:6]), .I_FILTER_CAPACITOR_PAIR_CODE(f[5:2]),
        .I_FIRST_LOOP_PUMP_FLOAT_BIT(f[1]), .I_SECOND_LOOP_PUMP_FLOAT_BIT(f[0]),
        .I_OUTPUT_ENABLE_PIN(pin), .O_FIRST_LOOP_PUMP_CURRENT_UA(outs[68:60]),
        .O_FIRST_LOOP_PUMP_CODE_BAD(outs[59]), .O_FIRST_LOOP_PUMP_INVERT(outs[58]),
        .O_CRYSTAL_AMPLIFIER_ON(outs[57]), .O_AUX_OUTPUT_ON(outs[56]),
        .O_OUTPUT_CLOCKS_ON(outs[55]), .O_DEVICE_POWERED(outs[54]),
        .O_DOUBLER_PATH_SELECT(outs[53]), .O_REFERENCE_DIVIDER_USED(outs[52]),
        .O_FILTER_FIRST_RESISTOR_OHM(outs[51:36]), .O_FILTER_SECOND_RESISTOR_OHM(outs[35:20]),
        .O_FILTER_RESISTOR_CODE_BAD(outs[19]), .O_FILTER_FIRST_CAP_PF(outs[18:11]),
        .O_FILTER_SECOND_CAP_PF(outs[10:3]), .O_FILTER_CAP_CODE_BAD(outs[2]),
        .O_FIRST_LOOP_PUMP_OUTPUT_OE(outs[1]), .O_SECOND_LOOP_PUMP_OUTPUT_OE(outs[0]));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] res_ohm(input logic [2:0] c, input logic [15:0] fl);
        return (c == 3'h0) ? fl : (c > 3'h4) ? 16'h0000 : 16'(c) * 16'h2710;
    endfunction
    // p is the synchronised pin level the outputs should already show
    function automatic logic [68:0] exp_out(input logic [20:0] v, input logic p);
        logic        on;
        logic [15:0] c;
        on = !v[13];
        c = (v[5:2] < 4'hc) ? cap_tab[v[5:2]] : 16'h0000;
        return {cur_tab[v[20:18]], v[20:19] == 2'h0, !v[17], v[16] & on, v[15] & on,
                v[14] & p & on, on, v[12] & on, !v[12] & on,
                res_ohm(v[11:9], loop_cfg_pkg::R1_FLOOR), res_ohm(v[8:6], loop_cfg_pkg::R2_FLOOR),
                (v[11:9] > 3'h4) || (v[8:6] > 3'h4), c, v[5:2] >= 4'hc, !v[1] & on, !v[0] & on};
    endfunction
    // leaves the strobe high so writes can follow back to back
    task automatic put(input logic [20:0] v);
        f = v;
        wr_en = 1'b1;
        @(negedge clk);
    endtask
    task automatic chk(input logic [68:0] e);
        wr_en = 1'b0;
        @(negedge clk);
        n_tests++;
        if (outs !== e) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, outs, e);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        logic [20:0] v;
        rst_n = 1'b0;
        wr_en = 1'b0;
        pin = 1'b0;
        f = 21'h000000;
        void'($urandom(76));
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        chk(exp_out(21'h084000, 1'b0));
        pin = 1'b1;
        repeat (6) @(negedge clk);
        chk(exp_out(21'h084000, 1'b1));
        $display("test defaults done");
        for (int i = 0; i < 16; i++) begin
            v = 21'($urandom());
            v[20:18] = i[2:0];
            v[11:9] = i[2:0];
            v[8:6] = ~i[2:0];
            v[5:2] = i[3:0];
            v[13] = i[0] ^ i[3];
            put(v);
            chk(exp_out(v, 1'b1));
        end
        $display("test code sweep done");
        for (int i = 0; i < 200; i++) begin
            put(21'($urandom()));
            v = 21'($urandom());
            put(v);
            chk(exp_out(v, 1'b1));
        end
        // doubling with the suggested on-chip filter; no 50/60 pair, nearest first cap kept
        v = 21'h085048;
        put(v);
        chk(exp_out(v, 1'b1));
        $display("test random writes done");
        pin = 1'b0;
        v = 21'h084000;
        put(v);
        repeat (6) @(negedge clk);
        chk(exp_out(v, 1'b0));
        pin = 1'b1;
        v = 21'h080000;
        put(v);
        repeat (6) @(negedge clk);
        chk(exp_out(v, 1'b1));
        $display("test clock gating done");
        rst_n = 1'b0;
        chk(69'h0);
        rst_n = 1'b1;
        chk(exp_out(21'h084000, 1'b0));
        $display("test mid-run reset done");
        finish_test();
    end
endmodule // tb

bind loop_cfg_fields loop_cfg_checker loop_cfg_checker_inst (
    .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .I_WR_EN(I_WR_EN),
    .I_FIRST_LOOP_PUMP_CURRENT_CODE(I_FIRST_LOOP_PUMP_CURRENT_CODE),
    .I_FIRST_LOOP_PUMP_SLOPE_SELECT(I_FIRST_LOOP_PUMP_SLOPE_SELECT),
    .I_WHOLE_DEVICE_SLEEP_BIT(I_WHOLE_DEVICE_SLEEP_BIT),
    .I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE(I_SECOND_LOOP_REFERENCE_DOUBLER_ENABLE),
    .I_FILTER_CAPACITOR_PAIR_CODE(I_FILTER_CAPACITOR_PAIR_CODE),
    .I_FIRST_LOOP_PUMP_FLOAT_BIT(I_FIRST_LOOP_PUMP_FLOAT_BIT),
    .I_SECOND_LOOP_PUMP_FLOAT_BIT(I_SECOND_LOOP_PUMP_FLOAT_BIT),
    .I_OUTPUT_ENABLE_PIN(I_OUTPUT_ENABLE_PIN),
    .O_FIRST_LOOP_PUMP_CURRENT_UA(O_FIRST_LOOP_PUMP_CURRENT_UA),
    .O_FIRST_LOOP_PUMP_INVERT(O_FIRST_LOOP_PUMP_INVERT), .O_OUTPUT_CLOCKS_ON(O_OUTPUT_CLOCKS_ON),
    .O_DEVICE_POWERED(O_DEVICE_POWERED), .O_DOUBLER_PATH_SELECT(O_DOUBLER_PATH_SELECT),
    .O_REFERENCE_DIVIDER_USED(O_REFERENCE_DIVIDER_USED),
    .O_FILTER_CAP_CODE_BAD(O_FILTER_CAP_CODE_BAD),
    .O_FIRST_LOOP_PUMP_OUTPUT_OE(O_FIRST_LOOP_PUMP_OUTPUT_OE),
    .O_SECOND_LOOP_PUMP_OUTPUT_OE(O_SECOND_LOOP_PUMP_OUTPUT_OE));
